/* File: rtl/dual_8bit_timer_pwm.sv */
// two 8-bit timers (C interval, D interval or PWM) with register access
//
// Overview of operation
// - clearing timer C bit 7 selects two 8-bit timers
// - timer C clock: fxx over 1024, 512, 8, 1
// - timer D clock: fxx over 8, 4, 2, 1
// - each timer: counter, comparator, reference register
// - control registers at D0H and D1H, read/write
// - timer C control resets to zero
// - timer D control resets to zero
// - timer C bit 3 write-one clears counter
// - timer D bit 3 write-one clears counter
// - match sets pending flag; software writes zero
// - pending flags set even with interrupts off
// - timer D overflow pending in pending bit 5
// - interval match: request, clear counter, keep counting
// - PWM match keeps counter running, wraps at FFH
// - PWM pin low when reference not above count
// - PWM period is 256 counting clocks
// - timer D pin carries match or PWM output
`timescale 1ns/10ps
module dual_8bit_timer_pwm
  import timer_pkg::*;
(
  input  wire logic       clk_i,                  // system clock fxx
  input  wire logic       rst_n_i,                // async reset, low
  input  wire logic [7:0] reg_addr_i,             // register address
  input  wire logic       reg_wr_i,               // write strobe
  input  wire logic [7:0] reg_wdata_i,            // write data
  output logic      [7:0] reg_rdata_o,            // read data, next cycle
  output logic            timer_c_match_irq_o,    // timer C request
  output logic            timer_d_match_irq_o,    // timer D match request
  output logic            timer_d_overflow_irq_o, // timer D wrap request
  output logic            pwm_output_pin_o,       // timer D output pin
  output logic            sixteen_bit_mode_o      // timers joined
);

  // register state

  logic [7:0] timer_c_control_reg;    // control of timer C
  logic [7:0] timer_d_control_reg;    // control of timer D
  logic [7:0] timer_c_reference_reg;  // timer C reference data
  logic [7:0] timer_d_reference_reg;  // timer D reference data
  logic       c_pending_reg;          // timer C match pending
  logic       d_match_pending_reg;    // timer D match pending
  logic       d_overflow_pending_reg; // timer D overflow pending
  logic [7:0] rdata_reg;              // registered read data
  logic       c_irq_reg;              // timer C request flop
  logic       d_match_irq_reg;        // timer D match request flop
  logic       d_overflow_irq_reg;     // timer D wrap request flop
  logic       pin_reg;                // timer D output pin flop
  logic       mode16_reg;             // copy of the joined-mode bit

  // write decode

  logic wr_c_control;    // write to timer C control
  logic wr_d_control;    // write to timer D control
  logic wr_c_reference;  // write to timer C reference
  logic wr_d_reference;  // write to timer D reference
  logic wr_pending;      // write to pending flags

  // one strobe per addressed register
  assign wr_c_control   = reg_wr_i && (reg_addr_i == TIMER_C_CONTROL_ADDR);
  assign wr_d_control   = reg_wr_i && (reg_addr_i == TIMER_D_CONTROL_ADDR);
  assign wr_c_reference = reg_wr_i
                          && (reg_addr_i == TIMER_C_REFERENCE_ADDR);
  assign wr_d_reference = reg_wr_i
                          && (reg_addr_i == TIMER_D_REFERENCE_ADDR);
  assign wr_pending     = reg_wr_i
                          && (reg_addr_i == TIMER_PENDING_FLAGS_ADDR);

  // control fields

  logic       split_mode;    // two 8-bit timers selected
  logic       c_run;         // timer C counting
  logic       d_run;         // timer D counting
  logic       c_clear;       // clear pulse for timer C
  logic       d_clear;       // clear pulse for timer D
  logic [3:0] c_shift;       // timer C divide as a shift
  logic [3:0] d_shift;       // timer D divide as a shift
  d_mode_type d_mode;        // timer D interval or PWM

  // joined mode stops both 8-bit timers
  assign split_mode = !timer_c_control_reg[MODE16_BIT];

  // each timer runs when enabled and the timers are split
  assign c_run = split_mode && timer_c_control_reg[ENABLE_BIT];
  assign d_run = split_mode && timer_d_control_reg[ENABLE_BIT];

  // counter clear is a write-one action taken in the write cycle
  assign c_clear = wr_c_control && reg_wdata_i[CLEAR_BIT];
  assign d_clear = wr_d_control && reg_wdata_i[CLEAR_BIT];

  // clock select fields to divide ratios
  assign c_shift = timer_c_shift(
    timer_c_control_reg[CLK_SEL_HI_BIT:CLK_SEL_LO_BIT]);
  assign d_shift = timer_d_shift(
    timer_d_control_reg[CLK_SEL_HI_BIT:CLK_SEL_LO_BIT]);

  // timer D mode field
  assign d_mode = d_mode_type'(timer_d_control_reg[PWM_MODE_BIT]);

  // prescalers and counters

  logic       c_tick;       // timer C counting clock
  logic       d_tick;       // timer D counting clock
  logic [7:0] c_count;      // timer C count
  logic [7:0] d_count;      // timer D count
  logic       c_match;      // timer C match event
  logic       d_match;      // timer D match event
  logic       d_overflow;   // timer D wrap event

  // timer C divider: 1024, 512, 8 or 1
  timer_prescaler #(
    .WIDTH   (PRESCALE_WIDTH)
  ) c_prescaler (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (c_clear),
    .run_i   (c_run),
    .shift_i (c_shift),
    .tick_o  (c_tick)
  );

  // timer D divider: 8, 4, 2 or 1
  timer_prescaler #(
    .WIDTH   (PRESCALE_WIDTH)
  ) d_prescaler (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (d_clear),
    .run_i   (d_run),
    .shift_i (d_shift),
    .tick_o  (d_tick)
  );

  // timer C is interval only, so a match always clears
  timer_counter8 #(
    .WIDTH       (8)
  ) c_counter (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .clear_i     (c_clear),
    .tick_i      (c_tick),
    .free_run_i  (1'b0),
    .reference_i (timer_c_reference_reg),
    .count_o     (c_count),
    .match_o     (c_match),
    .overflow_o  ()
  );

  // timer D runs freely in PWM mode
  timer_counter8 #(
    .WIDTH       (8)
  ) d_counter (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .clear_i     (d_clear),
    .tick_i      (d_tick),
    .free_run_i  (d_mode == MODE_PWM),
    .reference_i (timer_d_reference_reg),
    .count_o     (d_count),
    .match_o     (d_match),
    .overflow_o  (d_overflow)
  );

  // control registers

  // timer C control; clear bit never stored, pending handled apart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_c_control_reg <= CONTROL_RESET;
    end else if (wr_c_control) begin
      timer_c_control_reg <= reg_wdata_i;
      timer_c_control_reg[CLEAR_BIT] <= 1'b0;
      timer_c_control_reg[C_PENDING_BIT] <= 1'b0;
    end
  end

  // timer D control; clear bit never stored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_d_control_reg <= CONTROL_RESET;
    end else if (wr_d_control) begin
      timer_d_control_reg <= reg_wdata_i;
      timer_d_control_reg[CLEAR_BIT] <= 1'b0;
    end
  end

  // reference data registers loaded by software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_c_reference_reg <= REFERENCE_RESET;
      timer_d_reference_reg <= REFERENCE_RESET;
    end else begin
      if (wr_c_reference) begin
        timer_c_reference_reg <= reg_wdata_i;
      end
      if (wr_d_reference) begin
        timer_d_reference_reg <= reg_wdata_i;
      end
    end
  end

  // pending flags: hardware set wins over a software clear

  // timer C match pending, control bit 0; writing zero clears it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_pending_reg <= 1'b0;
    end else if (c_match) begin
      c_pending_reg <= 1'b1;
    end else if (wr_c_control && !reg_wdata_i[C_PENDING_BIT]) begin
      c_pending_reg <= 1'b0;
    end
  end

  // timer D match pending, pending register bit 4
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d_match_pending_reg <= 1'b0;
    end else if (d_match) begin
      d_match_pending_reg <= 1'b1;
    end else if (wr_pending && !reg_wdata_i[D_MATCH_PND_BIT]) begin
      d_match_pending_reg <= 1'b0;
    end
  end

  // timer D overflow pending, pending register bit 5
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d_overflow_pending_reg <= 1'b0;
    end else if (d_overflow) begin
      d_overflow_pending_reg <= 1'b1;
    end else if (wr_pending && !reg_wdata_i[D_OVF_PND_BIT]) begin
      d_overflow_pending_reg <= 1'b0;
    end
  end

  // interrupt requests: pending flag gated by its enables

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_irq_reg          <= 1'b0;
      d_match_irq_reg    <= 1'b0;
      d_overflow_irq_reg <= 1'b0;
    end else begin
      // timer C: split mode, enable and match enable
      c_irq_reg <= c_pending_reg && split_mode
                   && timer_c_control_reg[ENABLE_BIT]
                   && timer_c_control_reg[MATCH_IE_BIT];
      // timer D match: split mode, enable and match enable
      d_match_irq_reg <= d_match_pending_reg && split_mode
                         && timer_d_control_reg[ENABLE_BIT]
                         && timer_d_control_reg[MATCH_IE_BIT];
      // timer D wrap: split mode, enable and overflow enable
      d_overflow_irq_reg <= d_overflow_pending_reg && split_mode
                            && timer_d_control_reg[ENABLE_BIT]
                            && timer_d_control_reg[D_OVF_IE_BIT];
    end
  end

  // timer D output pin

  // interval mode toggles on each match; PWM compares reference
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_reg <= 1'b0;
    end else begin
      unique case (d_mode)
        MODE_INTERVAL: begin
          if (d_match) begin
            pin_reg <= !pin_reg;
          end
        end
        MODE_PWM: begin
          // high while reference above count, low otherwise
          pin_reg <= (timer_d_reference_reg > d_count);
        end
      endcase
    end
  end

  // joined-mode indication for the 16-bit timer logic elsewhere
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode16_reg <= 1'b0;
    end else begin
      mode16_reg <= !split_mode;
    end
  end

  // read data, registered one cycle after the address

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= UNMAPPED_READ;
    end else begin
      case (reg_addr_i)
        TIMER_C_CONTROL_ADDR: begin
          // stored fields plus live pending flag
          rdata_reg <= {timer_c_control_reg[7:1], c_pending_reg};
        end
        TIMER_D_CONTROL_ADDR: begin
          rdata_reg <= timer_d_control_reg;
        end
        TIMER_C_REFERENCE_ADDR: begin
          rdata_reg <= timer_c_reference_reg;
        end
        TIMER_D_REFERENCE_ADDR: begin
          rdata_reg <= timer_d_reference_reg;
        end
        TIMER_C_COUNT_ADDR: begin
          rdata_reg <= c_count;
        end
        TIMER_D_COUNT_ADDR: begin
          rdata_reg <= d_count;
        end
        TIMER_PENDING_FLAGS_ADDR: begin
          // bits belonging to other timers read as zero
          rdata_reg <= UNMAPPED_READ;
          rdata_reg[D_MATCH_PND_BIT] <= d_match_pending_reg;
          rdata_reg[D_OVF_PND_BIT]   <= d_overflow_pending_reg;
        end
        default: begin
          rdata_reg <= UNMAPPED_READ;  // unmapped address
        end
      endcase
    end
  end

  // outputs straight from flops

  assign reg_rdata_o            = rdata_reg;
  assign timer_c_match_irq_o    = c_irq_reg;
  assign timer_d_match_irq_o    = d_match_irq_reg;
  assign timer_d_overflow_irq_o = d_overflow_irq_reg;
  assign pwm_output_pin_o       = pin_reg;
  assign sixteen_bit_mode_o     = mode16_reg;

endmodule

/* File: inc/timer_pkg.sv */
// shared constants, types and helpers for the dual 8-bit timer block
package timer_pkg;

  // register addresses in the register addressing space
  localparam logic [7:0] TIMER_C_CONTROL_ADDR     = 8'hD0;
  localparam logic [7:0] TIMER_D_CONTROL_ADDR     = 8'hD1;
  localparam logic [7:0] TIMER_C_REFERENCE_ADDR   = 8'hD2;
  localparam logic [7:0] TIMER_D_REFERENCE_ADDR   = 8'hD3;
  localparam logic [7:0] TIMER_C_COUNT_ADDR       = 8'hD4;
  localparam logic [7:0] TIMER_D_COUNT_ADDR       = 8'hD5;
  localparam logic [7:0] TIMER_PENDING_FLAGS_ADDR = 8'hD6;

  // control register field positions
  localparam int MODE16_BIT     = 7;  // timer C control only
  localparam int PWM_MODE_BIT   = 6;  // timer D control only
  localparam int CLK_SEL_HI_BIT = 5;
  localparam int CLK_SEL_LO_BIT = 4;
  localparam int CLEAR_BIT      = 3;  // write-one action, reads zero
  localparam int ENABLE_BIT     = 2;
  localparam int MATCH_IE_BIT   = 1;
  localparam int C_PENDING_BIT  = 0;  // timer C control only
  localparam int D_OVF_IE_BIT   = 0;  // timer D control only

  // pending register field positions
  localparam int D_MATCH_PND_BIT = 4;
  localparam int D_OVF_PND_BIT   = 5;

  // reset values
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] REFERENCE_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // prescaler width: largest divide is 2**10
  localparam int PRESCALE_WIDTH = 10;

  // timer D operating mode
  typedef enum logic {
    MODE_INTERVAL = 1'b0,
    MODE_PWM      = 1'b1
  } d_mode_type;

  // timer C select: /1024, /512, /8, /1 as a shift count
  function automatic logic [3:0] timer_c_shift(input logic [1:0] sel);
    case (sel)
      2'h0:    timer_c_shift = 4'hA;
      2'h1:    timer_c_shift = 4'h9;
      2'h2:    timer_c_shift = 4'h3;
      default: timer_c_shift = 4'h0;
    endcase
  endfunction

  // timer D select: /8, /4, /2, /1 as a shift count
  function automatic logic [3:0] timer_d_shift(input logic [1:0] sel);
    case (sel)
      2'h0:    timer_d_shift = 4'h3;
      2'h1:    timer_d_shift = 4'h2;
      2'h2:    timer_d_shift = 4'h1;
      default: timer_d_shift = 4'h0;
    endcase
  endfunction

endpackage

/* File: rtl/timer_prescaler.sv */
// clock divider that yields a one-cycle tick every 2**shift cycles
`timescale 1ns/10ps
module timer_prescaler
  import timer_pkg::*;
#(
  parameter int WIDTH = PRESCALE_WIDTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clear_i,  // restart division phase
  input  wire logic             run_i,    // divider advances only when set
  input  wire logic [3:0]       shift_i,  // log2 of the divide ratio
  output logic                  tick_o    // one cycle per divided period
);

  logic [WIDTH-1:0] div_reg;   // free divide counter
  logic [WIDTH-1:0] mask;      // low bits that must all be ones

  // mask of the selected divide ratio; shift 0 gives a tick every cycle
  assign mask = ~({WIDTH{1'b1}} << shift_i);

  // divide counter, restarted by a clear so intervals start exactly
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
    end else if (clear_i || !run_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // tick on the last cycle of each divided period
  assign tick_o = run_i && !clear_i && ((div_reg & mask) == mask);

endmodule

/* File: rtl/timer_counter8.sv */
// 8-bit up-counter with reference comparator, match and wrap events
`timescale 1ns/10ps
module timer_counter8
  import timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clear_i,      // counter back to zero
  input  wire logic             tick_i,       // prescaled count enable
  input  wire logic             free_run_i,   // match does not clear
  input  wire logic [WIDTH-1:0] reference_i,  // comparator reference
  output logic      [WIDTH-1:0] count_o,      // present count
  output logic                  match_o,      // count equals reference
  output logic                  overflow_o    // wrap from all ones
);

  logic [WIDTH-1:0] count_reg;  // the up-counter
  logic             equal;      // comparator result

  // comparator between count and reference
  assign equal = (count_reg == reference_i);

  // events happen on a counting tick unless a clear overrides it
  assign match_o    = tick_i && !clear_i && equal;
  assign overflow_o = tick_i && !clear_i && (&count_reg)
                      && !(equal && !free_run_i);

  // counter: clear, reload on match in interval mode, else increment
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else if (clear_i) begin
      count_reg <= '0;
    end else if (tick_i) begin
      if (equal && !free_run_i) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  assign count_o = count_reg;

endmodule

/* File: verif/dual_timer_sva.sv */
// port-level concurrent checks for the dual 8-bit timer block
`timescale 1ns/10ps
module dual_timer_sva
  import timer_pkg::*;
(
  input wire logic       clk_i,                  // system clock
  input wire logic       rst_n_i,                // async reset, low
  input wire logic [7:0] reg_addr_i,             // register address
  input wire logic       reg_wr_i,               // write strobe
  input wire logic [7:0] reg_wdata_i,            // write data
  input wire logic [7:0] reg_rdata_o,            // read data
  input wire logic       timer_c_match_irq_o,    // timer C request
  input wire logic       timer_d_match_irq_o,    // timer D match request
  input wire logic       timer_d_overflow_irq_o, // timer D wrap request
  input wire logic       pwm_output_pin_o,       // timer D pin
  input wire logic       sixteen_bit_mode_o      // joined mode flag
);
  logic [7:0]  c_ctl_reg;  // shadow of timer C control
  logic [7:0]  d_ctl_reg;  // shadow of timer D control
  logic [15:0] gap_reg;    // cycles since last pin rise
  logic        pin_q_reg;  // pin one cycle back
  logic        steady_reg; // previous rise seen in fast pwm
  logic        rise;       // pin rising now
  logic        pwm_fast;   // pwm, enabled, divide by one
  assign rise     = pwm_output_pin_o & ~pin_q_reg;
  assign pwm_fast = d_ctl_reg[PWM_MODE_BIT] & d_ctl_reg[ENABLE_BIT] &
                    (d_ctl_reg[5:4] == 2'h3) & ~c_ctl_reg[MODE16_BIT];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // mirror control register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_ctl_reg <= 8'h00;
      d_ctl_reg <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == TIMER_C_CONTROL_ADDR) begin
      c_ctl_reg <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == TIMER_D_CONTROL_ADDR) begin
      d_ctl_reg <= reg_wdata_i;
    end
  end
  // measure the spacing of pin rises
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_reg    <= 16'h0000;
      pin_q_reg  <= 1'b0;
      steady_reg <= 1'b0;
    end else begin
      pin_q_reg <= pwm_output_pin_o;
      gap_reg   <= rise ? 16'h0001 : gap_reg + 16'h0001;
      if (reg_wr_i && reg_addr_i == TIMER_D_CONTROL_ADDR) begin
        steady_reg <= 1'b0;
      end else if (rise) begin
        steady_reg <= pwm_fast;
      end
    end
  end
  a_mode_follow: assert property (
    reg_wr_i && reg_addr_i == TIMER_C_CONTROL_ADDR |-> ##2
    sixteen_bit_mode_o == $past(reg_wdata_i[MODE16_BIT], 2))
    else $error("mode flag does not follow control bit 7");
  a_unmapped_zero: assert property (
    reg_addr_i < TIMER_C_CONTROL_ADDR || reg_addr_i > TIMER_PENDING_FLAGS_ADDR
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_pending_mask: assert property (
    reg_addr_i == TIMER_PENDING_FLAGS_ADDR |=> reg_rdata_o[3:0] == 4'h0 &&
    reg_rdata_o[7:6] == 2'h0) else $error("pending spare bits set");
  a_clear_reads0: assert property (
    reg_addr_i == TIMER_C_CONTROL_ADDR || reg_addr_i == TIMER_D_CONTROL_ADDR
    |=> !reg_rdata_o[CLEAR_BIT]) else $error("clear bit read back");
  a_c_clear: assert property (
    reg_wr_i && reg_addr_i == TIMER_C_CONTROL_ADDR && reg_wdata_i[CLEAR_BIT]
    && !reg_wdata_i[ENABLE_BIT] ##2 !reg_wr_i && reg_addr_i ==
    TIMER_C_COUNT_ADDR |=> reg_rdata_o == 8'h00) else $error("c not cleared");
  a_d_clear: assert property (
    reg_wr_i && reg_addr_i == TIMER_D_CONTROL_ADDR && reg_wdata_i[CLEAR_BIT]
    && !reg_wdata_i[ENABLE_BIT] ##2 !reg_wr_i && reg_addr_i ==
    TIMER_D_COUNT_ADDR |=> reg_rdata_o == 8'h00) else $error("d not cleared");
  a_c_irq_gate: assert property (
    timer_c_match_irq_o |-> $past(c_ctl_reg[ENABLE_BIT] &
    c_ctl_reg[MATCH_IE_BIT] & ~c_ctl_reg[MODE16_BIT]))
    else $error("timer C request while not enabled");
  a_dm_irq_gate: assert property (
    timer_d_match_irq_o |-> $past(d_ctl_reg[ENABLE_BIT] &
    d_ctl_reg[MATCH_IE_BIT] & ~c_ctl_reg[MODE16_BIT]))
    else $error("timer D match request while not enabled");
  a_ovf_irq_gate: assert property (
    timer_d_overflow_irq_o |-> $past(d_ctl_reg[ENABLE_BIT] &
    d_ctl_reg[D_OVF_IE_BIT] & ~c_ctl_reg[MODE16_BIT]))
    else $error("timer D wrap request while not enabled");
  a_pwm_period: assert property (
    rise && steady_reg && pwm_fast |-> gap_reg == 16'h0100)
    else $error("pwm period not 256 cycles");
endmodule
bind dual_8bit_timer_pwm dual_timer_sva dual_timer_sva_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .timer_c_match_irq_o(timer_c_match_irq_o),
  .timer_d_match_irq_o(timer_d_match_irq_o),
  .timer_d_overflow_irq_o(timer_d_overflow_irq_o),
  .pwm_output_pin_o(pwm_output_pin_o), .sixteen_bit_mode_o(sixteen_bit_mode_o)
);

/* File: verif/tb.sv */
// self-checking bench for the dual 8-bit timer block
`timescale 1ns/10ps
module tb
  import timer_pkg::*;
;
  logic       clk_i, rst_n_i, reg_wr_i;           // clock, reset, strobe
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o; // register port
  logic       timer_c_match_irq_o, timer_d_match_irq_o; // match requests
  logic       timer_d_overflow_irq_o, pwm_output_pin_o; // wrap, pin
  logic       sixteen_bit_mode_o;                 // joined mode flag
  int         bad_count, checked, n;              // counters, wait length
  logic [7:0] a, b;                               // read results
  dual_8bit_timer_pwm dual_8bit_timer_pwm_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .timer_c_match_irq_o(timer_c_match_irq_o),
    .timer_d_match_irq_o(timer_d_match_irq_o),
    .timer_d_overflow_irq_o(timer_d_overflow_irq_o),
    .pwm_output_pin_o(pwm_output_pin_o),
    .sixteen_bit_mode_o(sixteen_bit_mode_o)
  );
  // free-running system clock
  always #2 clk_i = ~clk_i;
  // verdict and end of run
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // a wait that ran out ends the run
  task automatic guard();
    if (n >= 3000) begin
      bad_count++;
      $display("FAIL wait expected event seen timeout");
      close_out();
    end
  endtask
  // one register write, strobe for one cycle
  task automatic wr(input logic [7:0] ad, d);
    @(posedge clk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  // one register read, data one cycle after the address
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= ad;
    @(posedge clk_i);
    #1 v = reg_rdata_o;
  endtask
  task automatic rdc(input logic [7:0] ad, exp, input string nm);
    rd(ad, b);
    chk(nm, {8'h00, b}, {8'h00, exp});
  endtask
  // count cycles while the pin stays at a level
  task automatic wait_lvl(input logic lvl);
    n = 0;
    while (pwm_output_pin_o === lvl && n < 3000) begin
      @(posedge clk_i);
      #1 n++;
    end
    guard();
  endtask
  // length of one whole run of the pin at a level
  task automatic run_len(input logic lvl, input int exp, input string nm);
    wait_lvl(lvl);
    wait_lvl(!lvl);
    wait_lvl(lvl);
    chk(nm, 16'(n), 16'(exp));
  endtask
  task automatic t_regs();
    rdc(TIMER_C_CONTROL_ADDR, 8'h00, "c control reset");
    rdc(TIMER_D_CONTROL_ADDR, 8'h00, "d control reset");
    rdc(TIMER_C_COUNT_ADDR, 8'h00, "c count reset");
    rdc(8'h10, 8'h00, "unmapped read");
    wr(TIMER_D_CONTROL_ADDR, 8'hC2);
    rdc(TIMER_D_CONTROL_ADDR, 8'hC2, "d control rw");
    wr(TIMER_D_CONTROL_ADDR, 8'h08);
    rdc(TIMER_D_COUNT_ADDR, 8'h00, "d count clear");
    wr(TIMER_C_CONTROL_ADDR, 8'h80);
    rdc(TIMER_C_CONTROL_ADDR, 8'h80, "c control rw");
    chk("mode flag", {15'h0, sixteen_bit_mode_o}, 16'h0001);
    wr(TIMER_C_CONTROL_ADDR, 8'h00);
    rdc(TIMER_C_CONTROL_ADDR, 8'h00, "split mode");
    chk("mode flag", {15'h0, sixteen_bit_mode_o}, 16'h0000);
    $display("test registers done");
  endtask
  task automatic t_c_rate();
    int div[4] = '{1024, 512, 8, 1};
    for (int s = 0; s < 4; s++) begin
      wr(TIMER_C_CONTROL_ADDR, {2'h0, 2'(s), 4'hC});
      rd(TIMER_C_COUNT_ADDR, a);
      repeat (4 * div[s] - 2) @(posedge clk_i);
      rd(TIMER_C_COUNT_ADDR, b);
      chk("c ticks", {8'h00, b - a}, 16'h0004);
    end
    wr(TIMER_C_CONTROL_ADDR, 8'h30);
    rd(TIMER_C_COUNT_ADDR, a);
    repeat (20) @(posedge clk_i);
    rdc(TIMER_C_COUNT_ADDR, a, "c count holds");
    wr(TIMER_C_CONTROL_ADDR, 8'h38);
    rdc(TIMER_C_COUNT_ADDR, 8'h00, "c count clear");
    $display("test timer C rate done");
  endtask
  task automatic t_c_match();
    wr(TIMER_C_REFERENCE_ADDR, 8'h03);
    wr(TIMER_C_CONTROL_ADDR, 8'h3C);
    n = 0;
    a = 8'h00;
    while (a[0] !== 1'b1 && n < 3000) begin
      rd(TIMER_C_CONTROL_ADDR, a);
      n++;
    end
    guard();
    chk("c request off", {15'h0, timer_c_match_irq_o}, 16'h0000);
    repeat (6) begin
      rd(TIMER_C_COUNT_ADDR, b);
      chk("c count range", {15'h0, b <= 8'h03}, 16'h0001);
    end
    wr(TIMER_C_CONTROL_ADDR, 8'h37);
    repeat (2) @(posedge clk_i);
    #1;
    chk("c request", {15'h0, timer_c_match_irq_o}, 16'h0001);
    wr(TIMER_C_CONTROL_ADDR, 8'h33);
    wr(TIMER_C_CONTROL_ADDR, 8'h32);
    rdc(TIMER_C_CONTROL_ADDR, 8'h32, "c pending clear");
    chk("c request", {15'h0, timer_c_match_irq_o}, 16'h0000);
    $display("test timer C match done");
  endtask
  task automatic t_d_timer();
    int dd[4] = '{8, 4, 2, 1};
    wr(TIMER_D_REFERENCE_ADDR, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(TIMER_D_CONTROL_ADDR, {2'h0, 2'(s), 4'hC});
      run_len(1'b1, dd[s], "d match pin");
    end
    wr(TIMER_D_REFERENCE_ADDR, 8'h40);
    wr(TIMER_PENDING_FLAGS_ADDR, 8'h00);
    wr(TIMER_D_CONTROL_ADDR, 8'h7F);
    run_len(1'b1, 64, "pwm high");
    run_len(1'b0, 192, "pwm low");
    rdc(TIMER_PENDING_FLAGS_ADDR, 8'h30, "d pending");
    chk("d match request", {15'h0, timer_d_match_irq_o}, 16'h1);
    chk("d wrap request", {15'h0, timer_d_overflow_irq_o}, 16'h1);
    wr(TIMER_D_CONTROL_ADDR, 8'h73);
    wr(TIMER_PENDING_FLAGS_ADDR, 8'h00);
    rdc(TIMER_PENDING_FLAGS_ADDR, 8'h00, "d pending clear");
    chk("d wrap request", {15'h0, timer_d_overflow_irq_o}, 16'h0);
    $display("test timer D done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    clk_i       = 1'b0;
    rst_n_i     = 1'b0;
    reg_wr_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    bad_count   = 0;
    checked     = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_c_rate();
    t_c_match();
    t_d_timer();
    close_out();
  end
endmodule
